// ---- src/cse_pkg.sv ----
/*
  Constants for the card socket event register block: register offsets,
  field positions, reset values and access widths.
  Assumes a 32-bit register port with byte offsets from the socket base.
*/
package cse_pkg;

  localparam int unsigned CSE_ADDR_W = 8;
  localparam int unsigned CSE_DATA_W = 32;

  // Register byte offsets from the socket base address
  localparam logic [7:0] CSE_OFF_CHANGE_FLAGS = 8'h00;
  localparam logic [7:0] CSE_OFF_IRQ_ENABLES = 8'h04;
  localparam logic [7:0] CSE_OFF_CURRENT_STATUS = 8'h08;
  localparam logic [7:0] CSE_OFF_EVENT_TRIGGER = 8'h0C;
  localparam logic [7:0] CSE_OFF_CONTROL = 8'h10;
  localparam logic [7:0] CSE_OFF_RSVD_FIRST = 8'h14;
  localparam logic [7:0] CSE_OFF_RSVD_LAST = 8'h1C;
  localparam logic [7:0] CSE_OFF_POWER_CONTROL = 8'h20;

  // Event, mask and status field positions
  localparam int unsigned CSE_BIT_CARD_STATUS = 0;
  localparam int unsigned CSE_BIT_DETECT_ONE = 1;
  localparam int unsigned CSE_BIT_DETECT_TWO = 2;
  localparam int unsigned CSE_BIT_POWER_CYCLE = 3;
  localparam int unsigned CSE_EVENT_W = 4;

  // Card detect mask field is two bits wide, enabled only at 11
  localparam logic [1:0] CSE_CD_MASK_ON = 2'h3;

  // Fixed socket voltage capability bits in the status register
  localparam logic [31:0] CSE_STATUS_FIXED = 32'h3000_0000;

  // Reset values
  localparam logic [3:0] CSE_EVENT_RESET = 4'h0;
  localparam logic [3:0] CSE_MASK_RESET = 4'h0;
  // Synchroniser reset: detect pins idle high, the other pins idle low
  localparam logic [4:0] CSE_PIN_IDLE = 5'h03;
  localparam logic [31:0] CSE_CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] CSE_POWER_RESET = 32'h0000_0000;

  // Power control: low half survives bus reset, high half does not
  localparam logic [31:0] CSE_POWER_GLOBAL_ONLY = 32'h0000_FFFF;
  localparam logic [31:0] CSE_POWER_WRITABLE = 32'h0000_FFFF;
  localparam logic [31:0] CSE_CONTROL_WRITABLE = 32'h0000_00FF;

  localparam logic [31:0] CSE_READ_ZERO = 32'h0000_0000;

endpackage : cse_pkg

// ---- src/cse_socket_regs.sv ----
/*
  Socket event register block: change flags, interrupt enables, current
  status, event trigger, control and power control registers.
  Assumes the register port and the card reset, reset-type and interrupt
  enable inputs come from logic on i_clock; card pins and the bus reset
  arrive asynchronously and are synchronised here.
*/
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// RULE1 - Five 32-bit socket registers reached through the register port.
// RULE2 - Flags 00h, enables 04h, status 08h, trigger 0Ch, control 10h.
// RULE3 - Extra power control register sits at offset 20h.
// RULE4 - Flags only record that a change happened; status shows the value.
// RULE5 - Writing one clears a flag; writing zero leaves it alone.
// RULE6 - Writing one to the trigger register sets that flag.
// RULE7 - Bus reset clears flags; leaving card reset re-flags live status.
// RULE8 - Interrupt when enabled and any flag is set and unmasked.
// RULE9 - Software clears pending flags before enabling interrupts.
// RULE10 - Flag register bits 31 to 4 read as zero.
// RULE11 - Flag 3 sets when power cycle status changes.
// RULE12 - Flag 2 sets when second card detect changes.
// RULE13 - Flag 1 sets when first card detect changes.
// RULE14 - CardBus card: flag 0 sets on rising status-change edge only.
// RULE15 - 16-bit card: flag 0 sets on both status-change edges.
// RULE16 - Context bits survive bus reset while power events are enabled.
// RULE17 - Some power control bits clear only on global reset.
// RULE18 - Flag register resets to all zeros.
// RULE19 - Enables gate only the interrupt, never flag setting.
// RULE20 - Card detect enable works only at 11; 00 off, others reserved.
// RULE21 - Card inputs synchronised, changes found against prior sample.
// RULE22 - Hardware set beats a same-cycle write-one clear.
module cse_socket_regs (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_bus_reset,
  input wire logic i_pme_enable,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [cse_pkg::CSE_ADDR_W-1:0] i_req_addr,
  input wire logic [cse_pkg::CSE_DATA_W-1:0] i_req_wdata,
  output logic o_req_ack,
  output logic [cse_pkg::CSE_DATA_W-1:0] o_req_rdata,
  input wire logic i_card_detect_one_n,
  input wire logic i_card_detect_two_n,
  input wire logic i_card_status_change,
  input wire logic i_power_cycle,
  input wire logic i_card_is_cardbus,
  input wire logic i_card_reset,
  input wire logic i_interrupts_enabled,
  output logic o_status_change_interrupt
);
  import cse_pkg::*;

  localparam int unsigned SYNC_W = 5;

  // Raw card pins, gathered for the synchroniser generate loop
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] prev_q;
  logic [SYNC_W-1:0] prev_d;
  logic bus_rst_s1_q;
  logic bus_rst_s2_q;

  // Register state
  logic [CSE_EVENT_W-1:0] flags_q;
  logic [CSE_EVENT_W-1:0] flags_d;
  logic power_cycle_irq_enable_q;
  logic power_cycle_irq_enable_d;
  logic [1:0] card_detect_irq_enable_q;
  logic [1:0] card_detect_irq_enable_d;
  logic card_status_irq_enable_q;
  logic card_status_irq_enable_d;
  logic [31:0] control_q;
  logic [31:0] control_d;
  logic [31:0] power_q;
  logic [31:0] power_d;
  logic card_reset_prev_q;
  logic card_reset_prev_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic irq_q;
  logic irq_d;

  // Decoded status and event terms
  logic card_detect_one_status;
  logic card_detect_two_status;
  logic card_status_field;
  logic power_cycle_status;
  logic card_is_cardbus;
  logic [CSE_EVENT_W-1:0] hw_set;
  logic [CSE_EVENT_W-1:0] sw_clear;
  logic [CSE_EVENT_W-1:0] sw_force;
  logic [CSE_EVENT_W-1:0] irq_gate;
  logic [31:0] status_word;
  logic wr_hit;
  logic bus_rst_now;
  logic card_reset_exit;

  assign pins_raw = {i_card_is_cardbus, i_power_cycle, i_card_status_change,
                     i_card_detect_two_n, i_card_detect_one_n};

  // Two flops per pin; only stage two and the prior sample feed logic
  // Reset to each pin's idle level, else release shows a false change
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_sync
      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          sync1_q[g] <= CSE_PIN_IDLE[g];
          sync2_q[g] <= CSE_PIN_IDLE[g];
        end else if (i_clk_en) begin
          sync1_q[g] <= pins_raw[g]; // [RULE21]
          sync2_q[g] <= sync1_q[g]; // [RULE21]
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      bus_rst_s1_q <= 1'b0;
      bus_rst_s2_q <= 1'b0;
    end else if (i_clk_en) begin
      bus_rst_s1_q <= i_bus_reset;
      bus_rst_s2_q <= bus_rst_s1_q;
    end
  end

  // Detect pins are active low at the socket
  assign card_detect_one_status = ~sync2_q[0];
  assign card_detect_two_status = ~sync2_q[1];
  assign card_status_field = sync2_q[2];
  assign power_cycle_status = sync2_q[3];
  assign card_is_cardbus = sync2_q[4];

  assign bus_rst_now = bus_rst_s2_q;
  assign card_reset_exit = card_reset_prev_q & ~i_card_reset;
  assign wr_hit = i_req_valid & i_req_write;

  // Hardware change detection against the previous sample
  always_comb begin
    hw_set = '0;
    hw_set[CSE_BIT_POWER_CYCLE] = sync2_q[3] ^ prev_q[3]; // [RULE11] [RULE21]
    hw_set[CSE_BIT_DETECT_TWO] = sync2_q[1] ^ prev_q[1]; // [RULE12] [RULE21]
    hw_set[CSE_BIT_DETECT_ONE] = sync2_q[0] ^ prev_q[0]; // [RULE13] [RULE21]
    if (card_is_cardbus) begin
      hw_set[CSE_BIT_CARD_STATUS] = sync2_q[2] & ~prev_q[2]; // [RULE14]
    end else begin
      hw_set[CSE_BIT_CARD_STATUS] = sync2_q[2] ^ prev_q[2]; // [RULE15]
    end
    // A card still present after card reset is reported again
    if (card_reset_exit) begin
      hw_set[CSE_BIT_DETECT_ONE] = hw_set[CSE_BIT_DETECT_ONE]
                                   | card_detect_one_status; // [RULE7]
      hw_set[CSE_BIT_DETECT_TWO] = hw_set[CSE_BIT_DETECT_TWO]
                                   | card_detect_two_status; // [RULE7]
      hw_set[CSE_BIT_CARD_STATUS] = hw_set[CSE_BIT_CARD_STATUS]
                                    | card_status_field; // [RULE7]
    end
  end

  // Software clear and force terms from the register port
  always_comb begin
    sw_clear = '0;
    sw_force = '0;
    if (wr_hit && i_req_addr == CSE_OFF_CHANGE_FLAGS) begin
      sw_clear = i_req_wdata[CSE_EVENT_W-1:0]; // [RULE5]
    end
    if (wr_hit && i_req_addr == CSE_OFF_EVENT_TRIGGER) begin
      sw_force = i_req_wdata[CSE_EVENT_W-1:0]; // [RULE6]
    end
  end

  // Interrupt gating; enables never touch flag setting
  always_comb begin
    irq_gate = '0;
    irq_gate[CSE_BIT_POWER_CYCLE] = power_cycle_irq_enable_q;
    irq_gate[CSE_BIT_CARD_STATUS] = card_status_irq_enable_q;
    // Reserved codes 01 and 10 act as disabled
    irq_gate[CSE_BIT_DETECT_ONE] =
      (card_detect_irq_enable_q == CSE_CD_MASK_ON); // [RULE20]
    irq_gate[CSE_BIT_DETECT_TWO] =
      (card_detect_irq_enable_q == CSE_CD_MASK_ON); // [RULE20]
  end

  // Status word: fixed bits plus live values, flags say nothing about the value
  always_comb begin
    status_word = CSE_STATUS_FIXED; // [RULE4]
    status_word[CSE_BIT_POWER_CYCLE] = power_cycle_status;
    status_word[CSE_BIT_DETECT_TWO] = card_detect_two_status;
    status_word[CSE_BIT_DETECT_ONE] = card_detect_one_status;
    status_word[CSE_BIT_CARD_STATUS] = card_status_field;
  end

  // Next-state logic for the whole register file
  always_comb begin
    prev_d = sync2_q;
    card_reset_prev_d = i_card_reset;
    flags_d = (flags_q & ~sw_clear) | sw_force | hw_set; // [RULE22] [RULE19]
    power_cycle_irq_enable_d = power_cycle_irq_enable_q;
    card_detect_irq_enable_d = card_detect_irq_enable_q;
    card_status_irq_enable_d = card_status_irq_enable_q;
    control_d = control_q;
    power_d = power_q;
    ack_d = i_req_valid;
    rdata_d = CSE_READ_ZERO;

    if (wr_hit) begin
      case (i_req_addr)
        CSE_OFF_IRQ_ENABLES: begin
          power_cycle_irq_enable_d = i_req_wdata[CSE_BIT_POWER_CYCLE];
          card_detect_irq_enable_d =
            i_req_wdata[CSE_BIT_DETECT_TWO:CSE_BIT_DETECT_ONE];
          card_status_irq_enable_d = i_req_wdata[CSE_BIT_CARD_STATUS];
        end
        CSE_OFF_CONTROL: begin
          control_d = i_req_wdata & CSE_CONTROL_WRITABLE;
        end
        CSE_OFF_POWER_CONTROL: begin
          power_d = i_req_wdata & CSE_POWER_WRITABLE; // [RULE3]
        end
        default: begin
          power_d = power_q;
        end
      endcase
    end

    // Reads return zero for reserved space and unmapped offsets
    if (i_req_valid && !i_req_write) begin
      case (i_req_addr)
        CSE_OFF_CHANGE_FLAGS: begin
          rdata_d = {28'h0000000, flags_q}; // [RULE10] [RULE2]
        end
        CSE_OFF_IRQ_ENABLES: begin
          rdata_d = {28'h0000000, power_cycle_irq_enable_q,
                     card_detect_irq_enable_q, card_status_irq_enable_q};
        end
        CSE_OFF_CURRENT_STATUS: begin
          rdata_d = status_word; // [RULE4]
        end
        CSE_OFF_CONTROL: begin
          rdata_d = control_q; // [RULE1]
        end
        CSE_OFF_POWER_CONTROL: begin
          rdata_d = power_q;
        end
        default: begin
          rdata_d = CSE_READ_ZERO;
        end
      endcase
    end

    // Bus reset spares context bits while power events are enabled
    if (bus_rst_now && !i_pme_enable) begin
      flags_d = CSE_EVENT_RESET; // [RULE7] [RULE16]
      power_cycle_irq_enable_d = CSE_MASK_RESET[CSE_BIT_POWER_CYCLE];
      card_detect_irq_enable_d =
        CSE_MASK_RESET[CSE_BIT_DETECT_TWO:CSE_BIT_DETECT_ONE]; // [RULE16]
      card_status_irq_enable_d = CSE_MASK_RESET[CSE_BIT_CARD_STATUS];
      control_d = CSE_CONTROL_RESET; // [RULE16]
    end
    if (bus_rst_now) begin
      // Global-only bits hold; the rest return to reset
      power_d = (power_d & CSE_POWER_GLOBAL_ONLY)
                | (CSE_POWER_RESET & ~CSE_POWER_GLOBAL_ONLY); // [RULE17]
    end

    // Pending flags raise the interrupt at once; software must clear first
    irq_d = i_interrupts_enabled & (|(flags_q & irq_gate)); // [RULE8] [RULE9]
  end

  // Global reset clears everything except the prior sample, which loads the pin idle levels
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      prev_q <= CSE_PIN_IDLE;
      card_reset_prev_q <= 1'b0;
      flags_q <= CSE_EVENT_RESET; // [RULE18]
      power_cycle_irq_enable_q <= 1'b0;
      card_detect_irq_enable_q <= 2'h0;
      card_status_irq_enable_q <= 1'b0;
      control_q <= CSE_CONTROL_RESET;
      power_q <= CSE_POWER_RESET; // [RULE17]
      ack_q <= 1'b0;
      rdata_q <= CSE_READ_ZERO;
      irq_q <= 1'b0;
    end else if (i_clk_en) begin
      prev_q <= prev_d;
      card_reset_prev_q <= card_reset_prev_d;
      flags_q <= flags_d;
      power_cycle_irq_enable_q <= power_cycle_irq_enable_d;
      card_detect_irq_enable_q <= card_detect_irq_enable_d;
      card_status_irq_enable_q <= card_status_irq_enable_d;
      control_q <= control_d;
      power_q <= power_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign o_req_ack = ack_q;
  assign o_req_rdata = rdata_q;
  assign o_status_change_interrupt = irq_q;

endmodule : cse_socket_regs

`default_nettype wire

// ---- testbench/cse_card_model.sv ----
/*
  Card in the socket: drives the detect pins, status-change and
  power-cycle lines from bench commands.
  Assumes commands change just after a rising edge of i_clock.
*/
`timescale 1ns/100ps
`default_nettype none
module cse_card_model (
  input wire logic i_clock,
  input wire logic i_insert,
  input wire logic i_sts,
  input wire logic i_pwr,
  input wire logic i_cardbus,
  output logic o_cd1_n,
  output logic o_cd2_n,
  output logic o_sts,
  output logic o_pwr,
  output logic o_cardbus
);
  initial begin
    o_cd1_n = 1'b1;
    o_cd2_n = 1'b1;
    o_sts = 1'b0;
    o_pwr = 1'b0;
    o_cardbus = 1'b0;
  end
  // Second contact mates a cycle late, as a real insertion does
  always @(posedge i_clock) begin
    o_cd1_n <= ~i_insert;
    o_cd2_n <= o_cd1_n;
    o_sts <= i_sts;
    o_pwr <= i_pwr;
    o_cardbus <= i_cardbus;
  end
endmodule : cse_card_model
`default_nettype wire

// ---- testbench/cse_socket_regs_sva.sv ----
/*
  Checker for the socket event register block, bound to its ports.
  Assumes single clock i_clock and async active-high i_rst.
*/
`timescale 1ns/100ps
`default_nettype none
module cse_socket_regs_sva (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [7:0] i_req_addr,
  input wire logic o_req_ack,
  input wire logic [31:0] o_req_rdata,
  input wire logic i_interrupts_enabled,
  input wire logic o_status_change_interrupt
);
  logic rd;
  logic wr_req;
  assign rd = i_clk_en && i_req_valid && !i_req_write;
  assign wr_req = i_clk_en && i_req_valid && i_req_write;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  AST_ACK: assert property (i_clk_en && i_req_valid |=> o_req_ack)
    else $error("request not acknowledged");
  AST_NO_ACK: assert property (!i_req_valid && i_clk_en
    |=> !o_req_ack) else $error("ack without request");
  AST_WR_ZERO: assert property (wr_req
    |=> o_req_rdata == 32'h0) else $error("write returned data");
  AST_FLAG_HI: assert property (rd && i_req_addr == 8'h00
    |=> o_req_rdata[31:4] == 28'h0) else $error("flag upper bits set");
  AST_MASK_HI: assert property (rd && i_req_addr == 8'h04
    |=> o_req_rdata[31:4] == 28'h0) else $error("enable upper bits set");
  AST_STATUS: assert property (rd && i_req_addr == 8'h08
    |=> o_req_rdata[31:4] == 28'h3000000) else $error("status fixed bits");
  AST_RSVD: assert property (rd && i_req_addr inside {8'h0C,
    8'h14, 8'h18, 8'h1C} |=> o_req_rdata == 32'h0)
    else $error("reserved read not zero");
  AST_POWER: assert property (rd && i_req_addr == 8'h20
    |=> o_req_rdata[31:16] == 16'h0) else $error("power upper bits set");
  AST_IRQ_OFF: assert property (!i_interrupts_enabled
    |=> !o_status_change_interrupt) else $error("interrupt while disabled");
  AST_RST: assert property (disable iff (1'b0) i_rst
    |-> !o_req_ack && o_req_rdata == 32'h0 && !o_status_change_interrupt)
    else $error("reset");
endmodule : cse_socket_regs_sva
bind cse_socket_regs cse_socket_regs_sva i_sva (.*);
`default_nettype wire

// ---- testbench/cse_socket_regs_tb.sv ----
/*
  Self-checking bench for the socket event register block.
  Assumes the card model and the bound checker are compiled alongside.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h want %h", $time, a, e); end end
module cse_socket_regs_tb;
  import cse_pkg::*;
  logic clk = 0, rst = 0, vld = 0, wr = 0, brst = 0, pme = 0;
  logic ints = 0, crst = 0, ins = 0, sts = 0, pwr = 0, cb = 0, en = 1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, q, rdata;
  logic ack, irq, cd1_n, cd2_n, csts, cpwr, ccb;
  logic [7:0] rs [4] = '{8'h0C, 8'h14, 8'h1C, 8'h21};
  int n_errors = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  cse_card_model i_card (.i_clock(clk), .i_insert(ins), .i_sts(sts),
    .i_pwr(pwr), .i_cardbus(cb), .o_cd1_n(cd1_n), .o_cd2_n(cd2_n),
    .o_sts(csts), .o_pwr(cpwr), .o_cardbus(ccb));
  cse_socket_regs i_dut (.i_clock(clk), .i_rst(rst), .i_clk_en(en),
    .i_bus_reset(brst), .i_pme_enable(pme), .i_req_valid(vld),
    .i_req_write(wr), .i_req_addr(adr), .i_req_wdata(wd), .o_req_ack(ack),
    .o_req_rdata(rdata), .i_card_detect_one_n(cd1_n),
    .i_card_detect_two_n(cd2_n), .i_card_status_change(csts),
    .i_power_cycle(cpwr), .i_card_is_cardbus(ccb), .i_card_reset(crst),
    .i_interrupts_enabled(ints), .o_status_change_interrupt(irq));
  task print_verdict;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // One-cycle request pulse; answer expected the following cycle
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    vld <= 1'b1;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    vld <= 1'b0;
    k = 0;
    // Ack and data are taken at the edge that samples them high
    @(posedge clk);
    while (ack !== 1'b1 && k < 4) begin
      @(posedge clk);
      k++;
    end
    if (k == 4) begin
      n_errors++;
      $display("wrong value at %0t: no ack", $time);
      print_verdict;
    end
    q = rdata;
  endtask : acc
  task w32(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask : w32
  task rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask : rd
  task bus_pulse;
    @(posedge clk);
    brst <= 1'b1;
    cyc(4);
    brst <= 1'b0;
    cyc(4);
  endtask : bus_pulse
  initial begin
    // Rising reset at time zero so every flop is reset before the first edge
    rst <= 1'b1;
    cyc(12);
    rst <= 1'b0;
    cyc(6);
    w32(8'h00, 32'hF);
    rd(8'h00, 32'h0);
    rd(8'h20, 32'h0);
    rd(8'h08, 32'h3000_0000);
    w32(8'h08, '1);
    w32(8'h14, '1);
    foreach (rs[i]) begin
      rd(rs[i], 32'h0);
    end
    w32(8'h04, '1);
    rd(8'h04, 32'hF);
    w32(8'h10, '1);
    rd(8'h10, 32'hFF);
    w32(8'h20, '1);
    rd(8'h20, 32'hFFFF);
    w32(8'h04, 32'h0);
    w32(8'h0C, 32'hF);
    rd(8'h00, 32'hF);
    w32(8'h00, 32'h5);
    rd(8'h00, 32'hA);
    w32(8'h00, 32'hA);
    ins <= 1'b1;
    cyc(8);
    rd(8'h00, 32'h6);
    rd(8'h08, 32'h3000_0006);
    w32(8'h00, 32'h6);
    pwr <= 1'b1;
    cyc(8);
    rd(8'h00, 32'h8);
    w32(8'h00, 32'h8);
    for (int c = 1; c >= 0; c--) begin
      cb <= c[0];
      cyc(6);
      sts <= 1'b1;
      cyc(8);
      rd(8'h00, 32'h1);
      w32(8'h00, 32'h1);
      sts <= 1'b0;
      cyc(8);
      rd(8'h00, {31'h0, ~c[0]});
      w32(8'h00, 32'h1);
    end
    w32(8'h0C, 32'hF);
    ints <= 1'b1;
    cyc(3);
    `CHK(irq, 1'b0)
    w32(8'h04, 32'h2);
    cyc(3);
    `CHK(irq, 1'b0)
    w32(8'h04, 32'h6);
    cyc(3);
    `CHK(irq, 1'b1)
    w32(8'h00, 32'h7);
    cyc(3);
    `CHK(irq, 1'b0)
    w32(8'h04, 32'h8);
    cyc(3);
    `CHK(irq, 1'b1)
    ints <= 1'b0;
    cyc(3);
    `CHK(irq, 1'b0)
    bus_pulse;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h20, 32'hFFFF);
    pme <= 1'b1;
    w32(8'h0C, 32'hF);
    w32(8'h04, 32'h9);
    bus_pulse;
    rd(8'h00, 32'hF);
    rd(8'h04, 32'h9);
    w32(8'h00, 32'hF);
    pme <= 1'b0;
    crst <= 1'b1;
    cyc(2);
    crst <= 1'b0;
    cyc(4);
    rd(8'h00, 32'h6);
    // A write offered while the clock enable is low must not land
    w32(8'h10, 32'h5A);
    en <= 1'b0;
    @(posedge clk);
    vld <= 1'b1;
    wr <= 1'b1;
    adr <= 8'h10;
    wd <= 32'h0;
    @(posedge clk);
    vld <= 1'b0;
    cyc(2);
    en <= 1'b1;
    rd(8'h10, 32'h5A);
    print_verdict;
  end
endmodule : cse_socket_regs_tb
`default_nettype wire
